// *** fcr_cmd_regs.sv ***
// APB register front end and command handshake for the file engine
//
// Summary of operation
// - Command codes: 00 format, 10 write files, 11 read files.
// - Writing a command while idle starts it and raises busy.
// - Busy clears when the engine finishes the running command.
// - Error bit follows the engine's error indication.
// - Read mismatch sets verify-fail; transfer carries on regardless.
// - Running byte count is readable while a command runs.
// - Disk information readable after a successful format.
// - Command write produces one request pulse to the engine.
// - Pattern codes: inc 000, dec 001, zeros 010, ones 011, LFSR 100.
//
// The placing of the registers and the APB interface to the registers were decided locally.
module fcr_cmd_regs (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire fcr_pkg::fcr_apb_req_t i_apb,
  output fcr_pkg::fcr_apb_rsp_t      o_apb,
  output logic                       o_irq,
  output logic                       o_cmd_req,
  output logic [1:0]                 o_cmd_code,
  output fcr_pkg::fcr_param_t        o_param,
  input  wire logic                  i_eng_busy,
  input  wire logic                  i_eng_error,
  input  wire fcr_pkg::fcr_disk_t    i_disk,
  output logic                       o_wr_valid,
  output logic [31:0]                o_wr_data,
  input  wire logic                  i_wr_ready,
  input  wire logic                  i_rd_valid,
  input  wire logic [31:0]           i_rd_data
);
  import fcr_pkg::*;

  fcr_regs_t   regs_r;
  fcr_regs_t   regs_nxt;
  logic        setup;
  logic        wr_en;
  logic        mapped;
  logic [31:0] rd_val;
  logic [2:0]  status;
  logic        cmd_take;
  logic        wr_beat;
  logic        rd_beat;
  logic        mismatch;
  logic [2:0]  irq_ev;
  logic [2:0]  irq_clr;
  logic [31:0] pat_word;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] zext27(input logic [26:0] v);
    zext27 = {5'h00, v};
  endfunction

  function automatic logic [31:0] zext3(input logic [2:0] v);
    zext3 = {29'h0000_0000, v};
  endfunction

  // Running phase of one command kind: gates beats and write valid
  function automatic logic run_of(input fcr_fsm_t   fsm,
                                  input logic [1:0] cur,
                                  input logic [1:0] kind);
    run_of = (fsm == ST_RUN) & (cur == kind);
  endfunction

  // Access phase of a write to one offset
  function automatic logic wr_hit(input fcr_apb_req_t req,
                                  input logic [11:0]  ofs);
    wr_hit = req.psel & req.penable & req.pwrite & (req.paddr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  assign setup = i_apb.psel & ~i_apb.penable;
  // Zero wait states, so every access phase completes
  assign wr_en = i_apb.psel & i_apb.penable & i_apb.pwrite;

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  // Busy also covers the engine's own start-up, so host waits on it
  assign status[ST_BUSY]  = (regs_r.fsm != ST_IDLE) | i_eng_busy;
  assign status[ST_ERR]   = i_eng_error;
  assign status[ST_VFAIL] = regs_r.vfail;

  // ----------------------------------------------------------------
  // Read decode (pure mux: status reads leave every bit alone)
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    unique case (i_apb.paddr)
      OFS_START_FILE: begin
        rd_val = zext27(regs_r.prm.start_file);
      end
      OFS_FILE_COUNT: begin
        rd_val = zext27(regs_r.prm.file_count);
      end
      OFS_FILE_SIZE: begin
        rd_val = zext3(regs_r.prm.file_size);
      end
      OFS_TIMESTAMP: begin
        rd_val = regs_r.prm.timestamp;
      end
      OFS_CMD_CODE: begin
        rd_val = 32'h0000_0000;
      end
      OFS_PATTERN: begin
        rd_val = zext3(regs_r.prm.pattern);
      end
      OFS_STATUS: begin
        rd_val = zext3(status);
      end
      OFS_MAX_FILES: begin
        rd_val = zext27(i_disk.max_files);
      end
      OFS_DIR_FILES: begin
        rd_val = {12'h000, i_disk.dir_files};
      end
      OFS_DISK_FSIZE: begin
        rd_val = zext3(i_disk.file_size);
      end
      OFS_DISK_FTOT: begin
        rd_val = zext27(i_disk.file_total);
      end
      OFS_CAP_LO: begin
        rd_val = i_disk.capacity[31:0];
      end
      OFS_CAP_HI: begin
        rd_val = {16'h0000, i_disk.capacity[47:32]};
      end
      OFS_XFER_LO: begin
        rd_val = regs_r.xfer[31:0];
      end
      OFS_XFER_HI: begin
        rd_val = {8'h00, regs_r.xfer[55:32]};
      end
      OFS_IRQ_STS: begin
        rd_val = zext3(regs_r.irq_sts);
      end
      OFS_IRQ_MASK: begin
        rd_val = zext3(regs_r.irq_mask);
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Command acceptance
  // ----------------------------------------------------------------
  // A new command is refused while one is still in flight
  assign cmd_take = wr_hit(i_apb, OFS_CMD_CODE)
                    & (regs_r.fsm == ST_IDLE) & ~i_eng_busy;

  // ----------------------------------------------------------------
  // Data beats
  // ----------------------------------------------------------------
  // Beats outside the running phase are neither counted nor checked
  assign wr_beat  = run_of(regs_r.fsm, regs_r.cmd, CMD_WRITE) & i_wr_ready;
  assign rd_beat  = run_of(regs_r.fsm, regs_r.cmd, CMD_READ) & i_rd_valid;
  assign mismatch = rd_beat & (i_rd_data != pat_word);

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  assign irq_clr = wr_hit(i_apb, OFS_IRQ_STS) ? i_apb.pwdata[2:0] : 3'h0;

  // Done marks the engine dropping busy, error its rising edge only
  assign irq_ev[IRQ_DONE]  = (regs_r.fsm == ST_RUN) & ~i_eng_busy;
  assign irq_ev[IRQ_ERR]   = i_eng_error & ~regs_r.err_d;
  assign irq_ev[IRQ_VFAIL] = mismatch;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    regs_nxt       = regs_r;
    regs_nxt.req   = 1'b0;
    regs_nxt.err_d = i_eng_error;

    if (setup) begin
      regs_nxt.prdata = rd_val;
    end

    if (wr_en) begin
      unique case (i_apb.paddr)
        OFS_START_FILE: begin
          regs_nxt.prm.start_file = i_apb.pwdata[26:0];
        end
        OFS_FILE_COUNT: begin
          regs_nxt.prm.file_count = i_apb.pwdata[26:0];
        end
        OFS_FILE_SIZE: begin
          regs_nxt.prm.file_size = i_apb.pwdata[2:0];
        end
        OFS_TIMESTAMP: begin
          regs_nxt.prm.timestamp = i_apb.pwdata;
        end
        OFS_PATTERN: begin
          regs_nxt.prm.pattern = i_apb.pwdata[2:0];
        end
        OFS_IRQ_MASK: begin
          regs_nxt.irq_mask = i_apb.pwdata[2:0];
        end
        OFS_CMD_CODE, OFS_IRQ_STS: begin
          // Taken by the command and interrupt paths
          regs_nxt.prm = regs_r.prm;
        end
        default: begin
          // Read-only and unmapped offsets drop the write
          regs_nxt.prm = regs_r.prm;
        end
      endcase
    end

    unique case (regs_r.fsm)
      ST_IDLE: begin
        if (cmd_take) begin
          regs_nxt.cmd   = i_apb.pwdata[1:0];
          regs_nxt.req   = 1'b1;
          regs_nxt.fsm   = ST_REQ;
          regs_nxt.vfail = 1'b0;
          regs_nxt.xfer  = 56'h00_0000_0000_0000;
        end
      end
      ST_REQ: begin
        // Hold busy until the engine takes over, or gives up
        if (i_eng_busy) begin
          regs_nxt.fsm = ST_RUN;
        end else if (irq_ev[IRQ_ERR]) begin
          // Only a fresh error; a stale one would drop the new command
          regs_nxt.fsm = ST_IDLE;
        end
      end
      ST_RUN: begin
        if (!i_eng_busy) begin
          regs_nxt.fsm = ST_IDLE;
        end
      end
      default: begin
        regs_nxt.fsm = ST_IDLE;
      end
    endcase

    // Count keeps running after a mismatch
    if (wr_beat || rd_beat) begin
      regs_nxt.xfer = regs_r.xfer + BYTES_PER_WORD;
    end
    if (mismatch) begin
      regs_nxt.vfail = 1'b1;
    end

    // New events win over a same-cycle clear
    regs_nxt.irq_sts = (regs_r.irq_sts & ~irq_clr) | irq_ev;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      regs_r.fsm      <= ST_IDLE;
      regs_r.cmd      <= CMD_FORMAT;
      regs_r.prm      <= '{timestamp: RST_TIMESTAMP,
                           file_size: 3'h0,
                           start_file: 27'h000_0000,
                           file_count: 27'h000_0000,
                           pattern: PAT_INC};
      regs_r.req      <= 1'b0;
      regs_r.vfail    <= 1'b0;
      regs_r.err_d    <= 1'b0;
      regs_r.irq_sts  <= 3'h0;
      regs_r.irq_mask <= 3'h0;
      regs_r.xfer     <= 56'h00_0000_0000_0000;
      regs_r.prdata   <= 32'h0000_0000;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pattern source shared by write data and read checking
  // ----------------------------------------------------------------
  fcr_pattern_gen u_pattern (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_load (cmd_take),
    .i_sel  (regs_r.prm.pattern),
    .i_adv  (wr_beat | rd_beat),
    .o_word (pat_word)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    o_apb.pready  = 1'b1;
    o_apb.pslverr = i_apb.psel & i_apb.penable & ~mapped;
    o_apb.prdata  = regs_r.prdata;
  end

  assign o_irq      = |(regs_r.irq_sts & regs_r.irq_mask);
  assign o_cmd_req  = regs_r.req;
  assign o_cmd_code = regs_r.cmd;
  assign o_param    = regs_r.prm;
  assign o_wr_valid = run_of(regs_r.fsm, regs_r.cmd, CMD_WRITE);
  assign o_wr_data  = pat_word;

endmodule // fcr_cmd_regs

// *** fcr_cmd_regs_monitor.sv ***
// Assertion checker for the file command register block
module fcr_cmd_regs_monitor
  import fcr_pkg::*;
(
  input wire logic                  i_clk,
  input wire logic                  i_rst,
  input wire fcr_pkg::fcr_apb_req_t i_apb,
  input wire fcr_pkg::fcr_apb_rsp_t o_apb,
  input wire logic                  o_irq,
  input wire logic                  o_cmd_req,
  input wire logic [1:0]            o_cmd_code,
  input wire fcr_pkg::fcr_param_t   o_param,
  input wire logic                  i_eng_busy,
  input wire logic                  i_eng_error,
  input wire logic                  o_wr_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic acc;
  logic wr;
  logic rd_st;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  assign acc   = i_apb.psel && i_apb.penable;
  assign wr    = acc && i_apb.pwrite;
  assign rd_st = acc && !i_apb.pwrite && i_apb.paddr == OFS_STATUS;

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_REQ_ONE: assert property (o_cmd_req |=> !o_cmd_req)
    else $error("command request wider than one cycle");
  AST_REQ_CAUSE: assert property (o_cmd_req |->
    $past(wr) && $past(i_apb.paddr) == OFS_CMD_CODE)
    else $error("command request without command write");
  AST_CODE: assert property (o_cmd_req |->
    o_cmd_code == $past(i_apb.pwdata[1:0]))
    else $error("command code differs from written value");
  AST_CODE_HOLD: assert property (!o_cmd_req |-> $stable(o_cmd_code))
    else $error("command code moved without request");
  AST_BUSY_REFUSE: assert property (wr && i_eng_busy &&
    i_apb.paddr == OFS_CMD_CODE |=> !o_cmd_req)
    else $error("command taken while busy");
  AST_ST_BUSY: assert property (rd_st && $past(i_eng_busy) |->
    o_apb.prdata[ST_BUSY])
    else $error("status busy low while engine busy");
  AST_ST_ERR: assert property (rd_st |->
    o_apb.prdata[ST_ERR] == $past(i_eng_error))
    else $error("status error bit differs from engine");
  AST_WR_CODE: assert property (o_wr_valid |-> o_cmd_code == CMD_WRITE)
    else $error("write data offered outside write command");
  AST_PAT: assert property (wr && i_apb.paddr == OFS_PATTERN |=>
    o_param.pattern == $past(i_apb.pwdata[2:0]))
    else $error("pattern select not taken");
  AST_UNMAPPED: assert property (acc && i_apb.paddr == 12'h07F0 |->
    o_apb.pslverr && o_apb.pready)
    else $error("unmapped access without error");
  AST_IRQ_MASK: assert property (wr && i_apb.paddr == OFS_IRQ_MASK &&
    i_apb.pwdata[2:0] == 3'h0 |-> ##2 !o_irq)
    else $error("interrupt high with all sources masked");

  COV_READ: cover property (o_cmd_req && o_cmd_code == CMD_READ);
  COV_FMT: cover property (o_cmd_req && o_cmd_code == CMD_FORMAT);
  COV_IRQ: cover property ($rose(o_irq));
endmodule  // fcr_cmd_regs_monitor

bind fcr_cmd_regs fcr_cmd_regs_monitor i_fcr_cmd_regs_monitor (
  .i_clk       (i_clk),
  .i_rst       (i_rst),
  .i_apb       (i_apb),
  .o_apb       (o_apb),
  .o_irq       (o_irq),
  .o_cmd_req   (o_cmd_req),
  .o_cmd_code  (o_cmd_code),
  .o_param     (o_param),
  .i_eng_busy  (i_eng_busy),
  .i_eng_error (i_eng_error),
  .o_wr_valid  (o_wr_valid)
);

// *** fcr_engine_model.sv ***
// Behavioural file engine model facing the command register block
module fcr_engine_model
  import fcr_pkg::*;
#(
  parameter int INIT_CYC = 20,
  parameter int NWORDS   = 8
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_cmd_req,
  input  wire logic [1:0] i_cmd_code,
  input  wire logic       i_wr_valid,
  input  wire logic       i_slow,
  input  wire logic       i_bad,
  input  wire logic       i_fail,
  output logic            o_busy,
  output logic            o_error,
  output logic            o_wr_ready,
  output logic            o_rd_valid,
  output logic [31:0]     o_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int          cnt;
  int          dly;
  logic        tog;
  logic        go;
  logic [31:0] word;

  // Slow mode stalls every other cycle
  assign go = o_busy && dly == 0 && cnt < NWORDS && (!i_slow || tog);
  assign o_wr_ready = go && i_cmd_code == CMD_WRITE;
  assign o_rd_valid = go && i_cmd_code == CMD_READ;
  assign word = (i_bad && cnt == 3) ? 32'h0000_0000 : 32'hFFFF_FFFF;
  // Released data lines show the inverse, never a stale word
  assign o_rd_data = o_rd_valid ? word : ~word;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_busy  <= 1'b1;
      o_error <= 1'b0;
      cnt     <= NWORDS;
      dly     <= INIT_CYC;
      tog     <= 1'b0;
    end else begin
      tog <= ~tog;
      if (dly > 0)
        dly <= dly - 1;
      if (i_cmd_req) begin
        o_busy  <= 1'b1;
        o_error <= 1'b0;
        cnt     <= (i_cmd_code == CMD_FORMAT) ? NWORDS : 0;
        dly     <= (i_cmd_code == CMD_FORMAT) ? 16 : 3;
      end else if (o_busy && dly == 1 && i_fail) begin
        o_error <= 1'b1;
        o_busy  <= 1'b0;
        cnt     <= NWORDS;
      end else if (o_busy && dly == 0 && cnt >= NWORDS) begin
        o_busy <= 1'b0;
      end else if ((o_wr_ready && i_wr_valid) || o_rd_valid) begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule  // fcr_engine_model

// *** fcr_pattern_gen.sv ***
// Test pattern generator feeding write data and read verification
module fcr_pattern_gen (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_load,
  input  wire logic [2:0]  i_sel,
  input  wire logic        i_adv,
  output logic [31:0]      o_word
);
  import fcr_pkg::*;

  fcr_pat_t pat_r;
  fcr_pat_t pat_nxt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    lfsr_step = v[0] ? ((v >> 1) ^ LFSR_TAPS) : (v >> 1);
  endfunction

  function automatic logic [31:0] pat_word(input logic [2:0]  sel,
                                           input logic [31:0] seq,
                                           input logic [31:0] lf);
    unique case (sel)
      PAT_INC:   pat_word = seq;
      PAT_DEC:   pat_word = ~seq;
      PAT_ZEROS: pat_word = 32'h0000_0000;
      PAT_ONES:  pat_word = 32'hFFFF_FFFF;
      PAT_LFSR:  pat_word = lf;
      default:   pat_word = seq;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    pat_nxt = pat_r;
    if (i_load) begin
      pat_nxt.sel  = i_sel;
      pat_nxt.seq  = 32'h0000_0000;
      pat_nxt.lfsr = LFSR_SEED;
      pat_nxt.word = pat_word(i_sel, 32'h0000_0000, LFSR_SEED);
    end else if (i_adv) begin
      pat_nxt.seq  = pat_r.seq + 32'h0000_0001;
      pat_nxt.lfsr = lfsr_step(pat_r.lfsr);
      pat_nxt.word = pat_word(pat_r.sel, pat_nxt.seq, pat_nxt.lfsr);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pat_r <= '{sel: PAT_INC, seq: 32'h0000_0000, lfsr: LFSR_SEED,
                 word: 32'h0000_0000};
    end else begin
      pat_r <= pat_nxt;
    end
  end

  assign o_word = pat_r.word;

endmodule // fcr_pattern_gen

// *** fcr_pkg.sv ***
// Shared constants and types for the file command register block
package fcr_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_START_FILE = 12'h000;
  localparam logic [11:0] OFS_FILE_COUNT = 12'h004;
  localparam logic [11:0] OFS_FILE_SIZE  = 12'h008;
  localparam logic [11:0] OFS_TIMESTAMP  = 12'h00C;
  localparam logic [11:0] OFS_CMD_CODE   = 12'h010;
  localparam logic [11:0] OFS_PATTERN    = 12'h014;
  localparam logic [11:0] OFS_STATUS     = 12'h100;
  localparam logic [11:0] OFS_MAX_FILES  = 12'h104;
  localparam logic [11:0] OFS_DIR_FILES  = 12'h114;
  localparam logic [11:0] OFS_DISK_FSIZE = 12'h118;
  localparam logic [11:0] OFS_DISK_FTOT  = 12'h11C;
  localparam logic [11:0] OFS_CAP_LO     = 12'h120;
  localparam logic [11:0] OFS_CAP_HI     = 12'h124;
  localparam logic [11:0] OFS_XFER_LO    = 12'h214;
  localparam logic [11:0] OFS_XFER_HI    = 12'h218;
  localparam logic [11:0] OFS_IRQ_STS    = 12'h300;
  localparam logic [11:0] OFS_IRQ_MASK   = 12'h304;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int unsigned ST_BUSY  = 0;
  localparam int unsigned ST_ERR   = 1;
  localparam int unsigned ST_VFAIL = 2;
  localparam int unsigned IRQ_DONE  = 0;
  localparam int unsigned IRQ_ERR   = 1;
  localparam int unsigned IRQ_VFAIL = 2;

  localparam logic [1:0] CMD_FORMAT = 2'h0;
  localparam logic [1:0] CMD_WRITE  = 2'h2;
  localparam logic [1:0] CMD_READ   = 2'h3;

  localparam logic [2:0] PAT_INC   = 3'h0;
  localparam logic [2:0] PAT_DEC   = 3'h1;
  localparam logic [2:0] PAT_ZEROS = 3'h2;
  localparam logic [2:0] PAT_ONES  = 3'h3;
  localparam logic [2:0] PAT_LFSR  = 3'h4;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_TIMESTAMP = 32'h0000_0000;
  localparam logic [31:0] LFSR_SEED     = 32'h0000_0001;
  localparam logic [31:0] LFSR_TAPS     = 32'h8020_0003;
  localparam logic [55:0] BYTES_PER_WORD = 56'h00_0000_0000_0004;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_REQ  = 3'b010,
    ST_RUN  = 3'b100
  } fcr_fsm_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } fcr_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } fcr_apb_rsp_t;

  typedef struct packed {
    logic [31:0] timestamp;
    logic [2:0]  file_size;
    logic [26:0] start_file;
    logic [26:0] file_count;
    logic [2:0]  pattern;
  } fcr_param_t;

  typedef struct packed {
    logic [26:0] max_files;
    logic [19:0] dir_files;
    logic [2:0]  file_size;
    logic [26:0] file_total;
    logic [47:0] capacity;
  } fcr_disk_t;

  typedef struct packed {
    fcr_fsm_t    fsm;
    logic [1:0]  cmd;
    fcr_param_t  prm;
    logic        req;
    logic        vfail;
    logic        err_d;
    logic [2:0]  irq_sts;
    logic [2:0]  irq_mask;
    logic [55:0] xfer;
    logic [31:0] prdata;
  } fcr_regs_t;

  typedef struct packed {
    logic [2:0]  sel;
    logic [31:0] seq;
    logic [31:0] lfsr;
    logic [31:0] word;
  } fcr_pat_t;

endpackage

// *** testbench.sv ***
// Self-checking bench for the file command register block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fcr_pkg::*;

  localparam int NW = 8;
  localparam fcr_disk_t DISK = '{27'h000_0123, 20'h0_0456, 3'h5,
                                 27'h000_0789, 48'h0000_1234_5678};
  logic         i_clk;
  logic         i_rst;
  fcr_apb_req_t apb_req;
  fcr_apb_rsp_t apb_rsp;
  fcr_param_t   prm;
  logic [1:0]   code;
  logic         irq, cmd_req, busy, err, slow, bad, fail, slv;
  logic         wr_valid, wr_ready, rd_valid;
  logic [31:0]  wr_data, rd_data, q;
  int           errors, total_checks, reqs;

  fcr_cmd_regs i_fcr_cmd_regs (.i_clk(i_clk), .i_rst(i_rst),
    .i_apb(apb_req), .o_apb(apb_rsp), .o_irq(irq), .o_cmd_req(cmd_req),
    .o_cmd_code(code), .o_param(prm), .i_eng_busy(busy),
    .i_eng_error(err), .i_disk(DISK), .o_wr_valid(wr_valid),
    .o_wr_data(wr_data), .i_wr_ready(wr_ready), .i_rd_valid(rd_valid),
    .i_rd_data(rd_data));
  fcr_engine_model #(.NWORDS(NW)) i_fcr_engine_model (.i_clk(i_clk),
    .i_rst(i_rst), .i_cmd_req(cmd_req), .i_cmd_code(code),
    .i_wr_valid(wr_valid), .i_slow(slow), .i_bad(bad), .i_fail(fail),
    .o_busy(busy), .o_error(err), .o_wr_ready(wr_ready),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) if (cmd_req === 1'b1) reqs++;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask

  // Setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge i_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge i_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 64);
    q = apb_rsp.prdata;
    slv = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    if (apb_rsp.pready !== 1'b1) begin
      errors++;
      report_and_stop();
    end
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask

  task automatic cmd(input logic [1:0] c);
    apb(1'b1, OFS_CMD_CODE, {30'h0000_0000, c});
  endtask

  // Poll until done or engine error; a mismatch alone keeps waiting
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      n++;
    end while (q[ST_BUSY] !== 1'b0 && q[ST_ERR] !== 1'b1 && n < 200);
    if (q[ST_BUSY] !== 1'b0 && q[ST_ERR] !== 1'b1) begin
      errors++;
      report_and_stop();
    end
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    i_rst = 1'b1;
    apb_req = '0;
    slow = 1'b0;
    bad = 1'b0;
    fail = 1'b0;
    errors = 0;
    total_checks = 0;
    reqs = 0;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    rc(OFS_STATUS, 32'h0000_0001);
    wait_idle();
    rc(OFS_MAX_FILES, {5'h00, DISK.max_files});
    rc(OFS_DIR_FILES, {12'h000, DISK.dir_files});
    rc(OFS_DISK_FSIZE, {29'h0000_0000, DISK.file_size});
    rc(OFS_DISK_FTOT, {5'h00, DISK.file_total});
    rc(OFS_CAP_LO, DISK.capacity[31:0]);
    rc(OFS_CAP_HI, {16'h0000, DISK.capacity[47:32]});
    rc(12'h07F0, 32'h0000_0000);
    chk({31'h0000_0000, slv}, 32'h0000_0001);
    for (int p = 0; p < 5; p++) begin
      apb(1'b1, OFS_PATTERN, 32'(p));
      @(negedge i_clk);
      chk({29'h0000_0000, prm.pattern}, 32'(p));
    end
    $display("test init done");
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
    apb(1'b1, OFS_TIMESTAMP, 32'h1234_5678);
    apb(1'b1, OFS_FILE_SIZE, 32'h0000_0003);
    cmd(CMD_FORMAT);
    rc(OFS_STATUS, 32'h0000_0001);
    cmd(CMD_READ);
    wait_idle();
    chk(32'(reqs), 32'h0000_0001);
    chk(prm.timestamp, 32'h1234_5678);
    chk({29'h0000_0000, prm.file_size}, 32'h0000_0003);
    rc(OFS_STATUS, 32'h0000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0007);
    @(negedge i_clk);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    apb(1'b1, OFS_IRQ_STS, 32'h0000_0001);
    @(negedge i_clk);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    $display("test format done");
    slow <= 1'b1;
    apb(1'b1, OFS_TIMESTAMP, 32'h0000_0042);
    apb(1'b1, OFS_START_FILE, 32'h0000_0010);
    apb(1'b1, OFS_FILE_COUNT, 32'h0000_0002);
    apb(1'b1, OFS_PATTERN, {29'h0000_0000, PAT_ONES});
    cmd(CMD_WRITE);
    wait_idle();
    rc(OFS_XFER_LO, 32'(NW * 4));
    rc(OFS_XFER_HI, 32'h0000_0000);
    chk(wr_data, 32'hFFFF_FFFF);
    chk({5'h00, prm.start_file}, 32'h0000_0010);
    chk({5'h00, prm.file_count}, 32'h0000_0002);
    $display("test write done");
    slow <= 1'b0;
    bad <= 1'b1;
    cmd(CMD_READ);
    wait_idle();
    rc(OFS_STATUS, 32'h0000_0004);
    rc(OFS_XFER_LO, 32'(NW * 4));
    rc(OFS_IRQ_STS, 32'h0000_0005);
    apb(1'b1, OFS_IRQ_STS, 32'h0000_0007);
    $display("test read done");
    bad <= 1'b0;
    fail <= 1'b1;
    apb(1'b1, OFS_PATTERN, {29'h0000_0000, PAT_LFSR});
    cmd(CMD_READ);
    wait_idle();
    rc(OFS_STATUS, 32'h0000_0002);
    apb(1'b0, OFS_IRQ_STS, 32'h0000_0000);
    chk({31'h0000_0000, q[IRQ_ERR]}, 32'h0000_0001);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    chk(wr_data, LFSR_SEED);
    fail <= 1'b0;
    $display("test error done");
    report_and_stop();
  end
endmodule  // testbench
